// ==== include/ovh_capture_map.svh ====
// register map, field positions and counts for the overhead capture block
//Contract
//- framing octet in bits 15..8
//- link status code in bits 2..0
//- mgmt octet two high, one low
//- growth octet two high, one low
//- growth octet three low, both modes
//- growth octet four high, zero in E3
//- growth octet five low, zero in E3
//- growth octet six high, zero in E3
//- irq needs latch, enable, port enable
//- octets four to six irq unused E3
`ifndef OVH_CAPTURE_MAP_SVH
`define OVH_CAPTURE_MAP_SVH
// register indices; the bus byte address is four times the index
`define IDX_FRAMING_LINK 7'h76
`define IDX_M1_M2 7'h78
`define IDX_Z1_Z2 7'h7a
`define IDX_Z3_Z4 7'h7c
`define IDX_Z5_Z6 7'h7e
`define IDX_CHANGE_LATCH 7'h60
`define IDX_CHANGE_CLEAR 7'h64
`define IDX_IRQ_ENABLE 7'h68
`define IDX_PORT_CTRL 7'h6c
`define OFS_FRAMING_LINK {`IDX_FRAMING_LINK, 2'h0}
`define OFS_M1_M2 {`IDX_M1_M2, 2'h0}
`define OFS_Z1_Z2 {`IDX_Z1_Z2, 2'h0}
`define OFS_Z3_Z4 {`IDX_Z3_Z4, 2'h0}
`define OFS_Z5_Z6 {`IDX_Z5_Z6, 2'h0}
`define OFS_CHANGE_LATCH {`IDX_CHANGE_LATCH, 2'h0}
`define OFS_CHANGE_CLEAR {`IDX_CHANGE_CLEAR, 2'h0}
`define OFS_IRQ_ENABLE {`IDX_IRQ_ENABLE, 2'h0}
`define OFS_PORT_CTRL {`IDX_PORT_CTRL, 2'h0}
`define PORT_CTRL_E3_BIT 0
`define PORT_CTRL_PORT_IE_BIT 1
`define NUM_FIELDS 10
`define FLD_LSS 0
`define FLD_F1 1
`define FLD_M1 2
`define FLD_M2 3
`define FLD_Z1 4
`define FLD_Z2 5
`define FLD_Z3 6
`define FLD_Z4 7
`define FLD_Z5 8
`define FLD_Z6 9
`define E3_UNUSED_MASK 10'h380
`define INTEGRATE_FRAMES 3'h3
`define RESET_WORD 16'h0000
`endif

// ==== include/ovh_capture_pkg.sv ====
// types for the overhead capture block
package ovh_capture_pkg;
  typedef logic [7:0] octet_t;
  typedef logic [9:0] field_mask_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS} bus_state_t;
endpackage

// ==== include/octet_link_if.sv ====
// carrier between the capture core and its integrator
`timescale 1ns/10ps
`default_nettype none
interface octet_link_if;
  logic strobe;
  logic [7:0] sample;
  logic [7:0] value;
  logic changed;
  modport core(output strobe, output sample, input value, input changed);
  modport filt(input strobe, input sample, output value, output changed);
endinterface
`default_nettype wire

// ==== hw/octet_integrator.sv ====
// persistence filter for one received overhead octet
`timescale 1ns/10ps
`default_nettype none
`include "ovh_capture_map.svh"
module octet_integrator
  import ovh_capture_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  octet_link_if.filt link
);
  octet_t candidate_reg;
  logic [2:0] count_reg;
  octet_t value_reg;
  logic changed_reg;
  assign link.value = value_reg;
  assign link.changed = changed_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      candidate_reg <= 8'h00;
      count_reg <= 3'h0;
      value_reg <= 8'h00;
      changed_reg <= 1'b0;
    end else if (clkEn) begin
      changed_reg <= 1'b0;
      if (link.strobe) begin
        if (link.sample != candidate_reg) begin
          candidate_reg <= link.sample;
          count_reg <= 3'h1;
        end else if (count_reg < `INTEGRATE_FRAMES) begin
          count_reg <= count_reg + 3'h1;
          if (count_reg + 3'h1 == `INTEGRATE_FRAMES &&
              value_reg != link.sample) begin
            value_reg <= link.sample;
            changed_reg <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/plcp_rx_overhead_byte_capture.sv ====
// APB register bank of integrated received overhead octets
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ovh_capture_map.svh"
module plcp_rx_overhead_byte_capture
  import ovh_capture_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic frameDone,
  input wire logic [7:0] rxFramingOctet,
  input wire logic [7:0] rxLinkStatusOctet,
  input wire logic [7:0] rxMgmtOctetOne,
  input wire logic [7:0] rxMgmtOctetTwo,
  input wire logic [7:0] rxGrowthOctetOne,
  input wire logic [7:0] rxGrowthOctetTwo,
  input wire logic [7:0] rxGrowthOctetThree,
  input wire logic [7:0] rxGrowthOctetFour,
  input wire logic [7:0] rxGrowthOctetFive,
  input wire logic [7:0] rxGrowthOctetSix,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  octet_t samples [`NUM_FIELDS];
  octet_t values [`NUM_FIELDS];
  field_mask_t changed;
  field_mask_t latch_reg;
  field_mask_t enable_reg;
  logic e3Mode_reg;
  logic portIe_reg;
  bus_state_t busState_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;

  // G1 bits 6..8 counted msb-first are bits 2..0 of the octet
  assign samples[`FLD_LSS] = {5'h00, rxLinkStatusOctet[2:0]};
  assign samples[`FLD_F1] = rxFramingOctet;
  assign samples[`FLD_M1] = rxMgmtOctetOne;
  assign samples[`FLD_M2] = rxMgmtOctetTwo;
  assign samples[`FLD_Z1] = rxGrowthOctetOne;
  assign samples[`FLD_Z2] = rxGrowthOctetTwo;
  assign samples[`FLD_Z3] = rxGrowthOctetThree;
  assign samples[`FLD_Z4] = rxGrowthOctetFour;
  assign samples[`FLD_Z5] = rxGrowthOctetFive;
  assign samples[`FLD_Z6] = rxGrowthOctetSix;

  genvar g;
  generate
    for (g = 0; g < `NUM_FIELDS; g++) begin : gFld
      octet_link_if link();
      assign link.strobe = frameDone;
      assign link.sample = samples[g];
      assign values[g] = link.value;
      assign changed[g] = link.changed;
      octet_integrator uInt (
        .clock(clock),
        .nrst(nrst),
        .clkEn(clkEn),
        .link(link.filt)
      );
    end
  endgenerate

  function automatic field_mask_t e3Gate(input field_mask_t m,
                                         input logic e3);
    e3Gate = e3 ? (m & ~`E3_UNUSED_MASK) : m;
  endfunction

  function automatic logic [15:0] readWord(input logic [8:0] a);
    if (a == `OFS_FRAMING_LINK) begin
      readWord = {values[`FLD_F1], 5'h00, values[`FLD_LSS][2:0]};
    end else if (a == `OFS_M1_M2) begin
      readWord = {values[`FLD_M2], values[`FLD_M1]};
    end else if (a == `OFS_Z1_Z2) begin
      readWord = {values[`FLD_Z2], values[`FLD_Z1]};
    end else if (a == `OFS_Z3_Z4) begin
      readWord = {e3Mode_reg ? 8'h00 : values[`FLD_Z4], values[`FLD_Z3]};
    end else if (a == `OFS_Z5_Z6) begin
      readWord = e3Mode_reg ? `RESET_WORD :
                 {values[`FLD_Z6], values[`FLD_Z5]};
    end else if (a == `OFS_CHANGE_LATCH) begin
      readWord = {6'h00, latch_reg};
    end else if (a == `OFS_IRQ_ENABLE) begin
      readWord = {6'h00, enable_reg};
    end else if (a == `OFS_PORT_CTRL) begin
      readWord = {14'h0000, portIe_reg, e3Mode_reg};
    end else begin
      readWord = `RESET_WORD;
    end
  endfunction

  // full compare, so a misaligned byte address is refused too
  function automatic logic known(input logic [8:0] a);
    known = (a == `OFS_FRAMING_LINK) || (a == `OFS_M1_M2) ||
            (a == `OFS_Z1_Z2) || (a == `OFS_Z3_Z4) ||
            (a == `OFS_Z5_Z6) || (a == `OFS_CHANGE_LATCH) ||
            (a == `OFS_CHANGE_CLEAR) || (a == `OFS_IRQ_ENABLE) ||
            (a == `OFS_PORT_CTRL);
  endfunction

  logic wrStrobe;
  assign wrStrobe = clkEn && busState_reg == BUS_ACCESS && psel &&
                    penable && pwrite;

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busState_reg <= BUS_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else if (clkEn) begin
      case (busState_reg)
        BUS_IDLE: begin
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          if (psel && penable && !pready_reg) begin
            busState_reg <= BUS_ACCESS;
            pready_reg <= 1'b1;
            pslverr_reg <= !known(paddr);
            prdata_reg <= pwrite ? 32'h00000000 : {16'h0000, readWord(paddr)};
          end
        end
        default: begin
          busState_reg <= BUS_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      enable_reg <= 10'h000;
      e3Mode_reg <= 1'b0;
      portIe_reg <= 1'b0;
    end else if (wrStrobe) begin
      if (paddr == `OFS_IRQ_ENABLE) begin
        enable_reg <= pwdata[9:0];
      end else if (paddr == `OFS_PORT_CTRL) begin
        e3Mode_reg <= pwdata[`PORT_CTRL_E3_BIT];
        portIe_reg <= pwdata[`PORT_CTRL_PORT_IE_BIT];
      end
    end
  end

  // new change wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      latch_reg <= 10'h000;
    end else if (clkEn) begin
      if (wrStrobe && paddr == `OFS_CHANGE_CLEAR) begin
        latch_reg <= (latch_reg & ~pwdata[9:0]) | changed;
      end else begin
        latch_reg <= latch_reg | changed;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      irq_reg <= portIe_reg &&
                 |(latch_reg & e3Gate(enable_reg, e3Mode_reg));
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// ==== verification/ovh_capture_properties.sv ====
// port assertions for the capture bank
`timescale 1ns/10ps
`default_nettype none
`include "ovh_capture_map.svh"
module ovh_capture_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire logic frameDone,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("late answer");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("long answer");
  a_idle_quiet: assert property (
    !psel |=> !pready) else $error("stray answer");
  a_error_timing: assert property (
    pslverr |-> pready) else $error("error alone");
  a_upper_zero: assert property (
    pready && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper set");
  a_link_spare: assert property (
    pready && !pwrite && paddr == `OFS_FRAMING_LINK |-> prdata[7:3] == 5'h0)
    else $error("spare bits set");
  a_refused_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data");
  a_reset_quiet: assert property (
    disable iff (1'b0) !nrst |=> !irq && !pready && prdata == 32'h0)
    else $error("busy in reset");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(frameDone, 2) || $past(frameDone, 3) ||
    $past(frameDone, 4) || $past(pready) || $past(pready, 2))
    else $error("irq without cause");
endmodule
bind plcp_rx_overhead_byte_capture ovh_capture_properties chk (.clock,
  .nrst, .frameDone, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .irq);
`default_nettype wire

// ==== verification/framer_model.sv ====
// receive framer stand-in handing over overhead octets
`timescale 1ns/10ps
`default_nettype none
module framer_model (
  input wire logic clock,
  input wire logic send,
  input wire logic [79:0] ovh,
  output logic frameDone,
  output logic [79:0] octets
);
  logic [2:0] gap = 3'h0;
  initial frameDone = 1'b0;
  initial octets = 80'h0;
  always @(posedge clock) begin
    gap <= gap + 3'h1;
    frameDone <= send && gap == 3'h7;
    // octets only valid with the pulse, garbage otherwise
    octets <= (send && gap == 3'h7) ? ovh : ~ovh;
  end
endmodule
`default_nettype wire

// ==== verification/tb_plcp_rx_overhead_byte_capture.sv ====
// bench for the overhead capture bank
`timescale 1ns/10ps
`default_nettype none
`include "ovh_capture_map.svh"
module tb_plcp_rx_overhead_byte_capture;
  logic clock = 1'b0, nrst = 1'b0, send = 1'b0, e3 = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, frameDone;
  logic [79:0] ovh = 80'h0, cur = 80'h0, oct;
  logic [32:0] q [$];
  // last two: unmapped and misaligned, both refused
  logic [8:0] addrs [7] = '{`OFS_FRAMING_LINK, `OFS_M1_M2, `OFS_Z1_Z2,
    `OFS_Z3_Z4, `OFS_Z5_Z6, 9'h000, 9'h1e2};
  int err_total = 0, checks = 0;
  always #25 clock = ~clock;
  framer_model frm (.clock, .send, .ovh, .frameDone, .octets(oct));
  plcp_rx_overhead_byte_capture DUT (.clock, .nrst, .clkEn(1'b1),
    .frameDone, .rxLinkStatusOctet(oct[7:0]), .rxFramingOctet(oct[15:8]),
    .rxMgmtOctetOne(oct[23:16]), .rxMgmtOctetTwo(oct[31:24]),
    .rxGrowthOctetOne(oct[39:32]), .rxGrowthOctetTwo(oct[47:40]),
    .rxGrowthOctetThree(oct[55:48]), .rxGrowthOctetFour(oct[63:56]),
    .rxGrowthOctetFive(oct[71:64]), .rxGrowthOctetSix(oct[79:72]),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq);
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e,
                     input logic [32:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [32:0] word(input logic [8:0] a);
    logic [7:0] o [10];
    for (int i = 0; i < 10; i++) o[i] = cur[8*i +: 8];
    // growth octets four to six blank in E3
    for (int i = 7; i < 10; i++) o[i] = e3 ? 8'h00 : o[i];
    case (a)
      `OFS_FRAMING_LINK: return {17'h0, o[1], 5'h00, o[0][2:0]};
      `OFS_M1_M2: return {17'h0, o[3], o[2]};
      `OFS_Z1_Z2: return {17'h0, o[5], o[4]};
      `OFS_Z3_Z4: return {17'h0, o[7], o[6]};
      `OFS_Z5_Z6: return {17'h0, o[9], o[8]};
      default: return {1'b1, 32'h0};
    endcase
  endfunction
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      chk("pready", 33'h1, 33'h0);
      print_verdict;
    end
  endtask
  task readAll(input string n);
    foreach (addrs[i]) begin
      q.push_back(word(addrs[i]));
      apb(1'b0, addrs[i], 32'h0);
    end
    $display("test %s done", n);
  endtask
  task automatic frames(input int n, input bit fresh);
    int seen;
    seen = 0;
    @(posedge clock);
    if (fresh) ovh <= {16'($urandom), $urandom, $urandom};
    send <= 1'b1;
    for (int k = 0; k < 40 * n && seen < n; k++) begin
      @(negedge clock);
      seen += int'(frameDone);
    end
    @(posedge clock);
    send <= 1'b0;
    if (seen < n) begin
      chk("frames", 33'h1, 33'h0);
      print_verdict;
    end
  endtask
  task irqIs(input logic v);
    repeat (4) @(negedge clock);
    chk("irq", {32'h0, v}, {32'h0, irq});
  endtask
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (q.size() == 0) chk("spare read", 33'h0, 33'h1);
      else chk("prdata", q.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    void'($urandom(32'h56f09e38));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    readAll("reset");
    frames(2, 1'b1);
    readAll("two frames");
    frames(1, 1'b0);
    cur = ovh;
    apb(1'b1, `OFS_M1_M2, 32'hffff);
    readAll("three frames");
    irqIs(1'b0);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h3ff);
    apb(1'b1, `OFS_PORT_CTRL, 32'h2);
    irqIs(1'b1);
    apb(1'b1, `OFS_CHANGE_CLEAR, 32'h3ff);
    irqIs(1'b0);
    // cleared latch reads back empty
    q.push_back(33'h0);
    apb(1'b0, `OFS_CHANGE_LATCH, 32'h0);
    $display("test irq done");
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h380);
    apb(1'b1, `OFS_PORT_CTRL, 32'h3);
    e3 = 1'b1;
    frames(3, 1'b1);
    cur = ovh;
    irqIs(1'b0);
    readAll("e3 mode");
    // mid-run reset brings every field and the mode back to zero
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    e3 = 1'b0;
    cur = 80'h0;
    irqIs(1'b0);
    readAll("second reset");
    repeat (5) @(posedge clock);
    print_verdict;
  end
endmodule
`default_nettype wire
